/* ros_pkg.sv */
package ros_pkg;

    // ------------------------------------------------------------
    // Fixed-point formats
    // ------------------------------------------------------------
    // Percentages are held in tenths of a percent (1000 = 100.0 %)
    localparam int PCT_W = 16;
    // Speeds are held in tenths of a hertz
    localparam int SPD_W = 16;

    // ------------------------------------------------------------
    // Setting ranges and defaults, tenths of a percent
    // ------------------------------------------------------------
    localparam logic signed [PCT_W-1:0] SCALE_MIN   = 16'sh0000; // 0.0 %
    localparam logic signed [PCT_W-1:0] SCALE_MAX   = 16'sh4e20; // 2000.0 %
    localparam logic signed [PCT_W-1:0] SCALE_DEF   = 16'sh03e8; // 100.0 %
    localparam logic signed [PCT_W-1:0] OFFSET_MIN  = -16'sh1388; // -500.0 %
    localparam logic signed [PCT_W-1:0] OFFSET_MAX  = 16'sh1388; // 500.0 %
    localparam logic signed [PCT_W-1:0] OFFSET_DEF  = 16'sh0000; // 0.0 %
    localparam logic signed [PCT_W-1:0] THRESH_MIN  = 16'sh0000; // 0.0 %
    localparam logic signed [PCT_W-1:0] THRESH_MAX  = 16'sh07d0; // 200.0 %
    localparam logic signed [PCT_W-1:0] THRESH_DEF  = 16'sh03e8; // 100.0 %
    localparam logic signed [PCT_W-1:0] HYST_MIN    = 16'sh0000; // 0.0 %
    localparam logic signed [PCT_W-1:0] HYST_MAX    = 16'sh03e8; // 100.0 %
    localparam logic signed [PCT_W-1:0] HYST_DEF    = 16'sh0000; // 0.0 %
    // Unity of the scale factor, used as divisor
    localparam logic signed [31:0]      SCALE_UNITY = 32'sh000003e8;
    // Control source code selecting follower mode
    localparam logic [3:0]              SRC_FOLLOW  = 4'h9;

    // ------------------------------------------------------------
    // Relay function codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FN_RUNNING   = 4'b0000,
        FN_HEALTHY   = 4'b0001,
        FN_AT_SPEED  = 4'b0010,
        FN_TRIPPED   = 4'b0011,
        FN_SPD_ABOVE = 4'b0100,
        FN_CUR_ABOVE = 4'b0101,
        FN_SPD_BELOW = 4'b0110,
        FN_CUR_BELOW = 4'b0111,
        FN_AIN2_ABOVE= 4'b1000,
        FN_READY     = 4'b1001
    } ros_fn_e;
    localparam logic [3:0] FN_DEF = 4'h1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Drive status flags from the rest of the drive
    typedef struct packed {
        logic motorEnabled;
        logic powerOk;
        logic fault;
        logic atSpeed;
        logic readyToRun;
    } ros_status_s;

    // Measured quantities, tenths of a percent of full scale
    typedef struct packed {
        logic signed [PCT_W-1:0] speedPct;
        logic signed [PCT_W-1:0] currentPct;
        logic signed [PCT_W-1:0] ain1Pct;
        logic signed [PCT_W-1:0] ain2Pct;
    } ros_meas_s;

    // Settings
    typedef struct packed {
        logic [3:0]              relayFunction;
        logic signed [PCT_W-1:0] threshold;
        logic signed [PCT_W-1:0] hysteresis;
        logic signed [PCT_W-1:0] scale;
        logic signed [PCT_W-1:0] offset;
        logic [3:0]              controlSource;
    } ros_cfg_s;

endpackage : ros_pkg

/* ros_relay_select.sv */
`timescale 1ns/1ps

module ros_relay_select
    import ros_pkg::*;
(
    input  wire logic                    clock,            // 20 MHz system clock
    input  wire logic                    reset_n,          // Async reset, active low
    input  wire ros_cfg_s                cfg,              // Settings, defaults at reset
    input  wire logic                    cfgLoad,          // Take new settings
    input  wire ros_status_s             status,           // Drive status flags
    input  wire ros_meas_s               meas,             // Measured quantities
    input  wire logic signed [SPD_W-1:0] masterSpeed,      // Master speed, 0.1 Hz
    input  wire logic signed [SPD_W-1:0] minSpeed,         // Minimum speed, 0.1 Hz
    input  wire logic signed [SPD_W-1:0] maxSpeed,         // Maximum speed, 0.1 Hz
    output logic                         relayActive,      // Relay contacts closed
    output logic signed [31:0]           ain1_result_display, // Scaled result, 0.1 %
    output logic signed [SPD_W-1:0]      followerSpeed,    // Follower speed, 0.1 Hz
    output logic                         followerMode      // Follower mode in force
);

    // ------------------------------------------------------------
    // Setting registers
    // ------------------------------------------------------------
    logic [3:0]              relayFunction;  // Held function code
    logic signed [PCT_W-1:0] threshold;      // Held threshold
    logic signed [PCT_W-1:0] hysteresis;     // Held hysteresis
    logic signed [PCT_W-1:0] scale;          // Held scale factor
    logic signed [PCT_W-1:0] offset;         // Held offset
    logic [3:0]              controlSource;  // Held control source

    // Clamp helper for settings
    function automatic logic signed [PCT_W-1:0] clampPct(
        input logic signed [PCT_W-1:0] v,
        input logic signed [PCT_W-1:0] lo,
        input logic signed [PCT_W-1:0] hi
    );
        logic signed [PCT_W-1:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clampPct

    // Out of range codes fall back to the default
    wire logic [3:0] next_relayFunction = (cfg.relayFunction > 4'h9) ? FN_DEF
                                          : cfg.relayFunction;

    // Settings load, percentage settings clamped to their ranges
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            relayFunction <= FN_DEF;
            threshold     <= THRESH_DEF;
            hysteresis    <= HYST_DEF;
            scale         <= SCALE_DEF;
            offset        <= OFFSET_DEF;
            controlSource <= 4'h0;
        end else if (cfgLoad) begin
            relayFunction <= next_relayFunction;
            threshold     <= clampPct(cfg.threshold, THRESH_MIN, THRESH_MAX);
            hysteresis    <= clampPct(cfg.hysteresis, HYST_MIN, HYST_MAX);
            scale         <= clampPct(cfg.scale, SCALE_MIN, SCALE_MAX);
            offset        <= clampPct(cfg.offset, OFFSET_MIN, OFFSET_MAX);
            controlSource <= cfg.controlSource;
        end
    end

    // ------------------------------------------------------------
    // Analog input one scaling and offset
    // ------------------------------------------------------------
    // Difference of input and offset, widened
    wire logic signed [17:0] ainDiff = 18'(meas.ain1Pct) - 18'(offset);
    // Product with the scale factor, tenths times tenths
    wire logic signed [35:0] ainProd = 36'(ainDiff) * 36'(scale);
    // Back to tenths of a percent
    wire logic signed [35:0] ainQuot = ainProd / 36'(SCALE_UNITY);
    wire logic signed [31:0] next_ain1Result = ainQuot[31:0];

    // ------------------------------------------------------------
    // Follower speed
    // ------------------------------------------------------------
    wire logic signed [35:0] spdProd = 36'(masterSpeed) * 36'(scale);
    wire logic signed [35:0] spdQuot = spdProd / 36'(SCALE_UNITY);
    wire logic               spdLow  = spdQuot < 36'(minSpeed);
    wire logic               spdHigh = spdQuot > 36'(maxSpeed);
    wire logic signed [SPD_W-1:0] next_followerSpeed =
        spdLow  ? minSpeed :
        spdHigh ? maxSpeed : spdQuot[SPD_W-1:0];
    wire logic next_followerMode = (controlSource == SRC_FOLLOW);

    // Computed results registered
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ain1_result_display <= 32'sh00000000;
            followerSpeed       <= 16'sh0000;
            followerMode        <= 1'b0;
        end else begin
            ain1_result_display <= next_ain1Result;
            followerSpeed       <= next_followerMode ? next_followerSpeed
                                                     : 16'sh0000;
            followerMode        <= next_followerMode;
        end
    end

    // ------------------------------------------------------------
    // Threshold comparison with hysteresis
    // ------------------------------------------------------------
    // Compared quantity for the selected function
    wire logic signed [PCT_W-1:0] cmpValue =
        (relayFunction == FN_CUR_ABOVE || relayFunction == FN_CUR_BELOW) ? meas.currentPct :
        (relayFunction == FN_AIN2_ABOVE) ? meas.ain2Pct : meas.speedPct;
    // Upper and lower switching points
    wire logic signed [17:0] upperPt = 18'(threshold) + 18'(hysteresis);
    wire logic signed [17:0] lowerPt = 18'(threshold) - 18'(hysteresis);
    wire logic               aboveUp = 18'(cmpValue) >  upperPt;
    wire logic               belowLo = 18'(cmpValue) <  lowerPt;
    wire logic               atOrUp  = 18'(cmpValue) >= upperPt;
    wire logic               atOrLo  = 18'(cmpValue) <= lowerPt;
    // With no band the plain compare points apply
    wire logic               noBand  = (hysteresis == HYST_MIN);
    wire logic               goHigh  = noBand ? atOrUp : aboveUp;
    wire logic               goLow   = noBand ? !atOrLo : belowLo;
    logic                    overThresh;  // Held compare state
    // Function change restarts comparison from raw level
    logic [3:0]              lastFunction;
    wire logic               fnChanged = (lastFunction != relayFunction);
    wire logic               next_overThresh =
        fnChanged ? atOrUp :
        goHigh    ? 1'b1 :
        (noBand ? !atOrUp : belowLo) ? 1'b0 : overThresh;

    // Compare state tracking
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            overThresh   <= 1'b0;
            lastFunction <= FN_DEF;
        end else begin
            overThresh   <= next_overThresh;
            lastFunction <= relayFunction;
        end
    end

    // ------------------------------------------------------------
    // Relay function selection
    // ------------------------------------------------------------
    logic next_relay;  // Selected condition

    // Condition multiplexer
    always_comb begin
        next_relay = 1'b0;
        unique case (ros_fn_e'(relayFunction))
            FN_RUNNING:    next_relay = status.motorEnabled;
            FN_HEALTHY:    next_relay = status.powerOk && !status.fault;
            FN_AT_SPEED:   next_relay = status.atSpeed;
            FN_TRIPPED:    next_relay = status.fault;
            FN_SPD_ABOVE:  next_relay = overThresh;
            FN_CUR_ABOVE:  next_relay = overThresh;
            FN_SPD_BELOW:  next_relay = !overThresh;
            FN_CUR_BELOW:  next_relay = !overThresh;
            FN_AIN2_ABOVE: next_relay = overThresh;
            FN_READY:      next_relay = status.readyToRun && !status.fault;
            default:       next_relay = 1'b0;
        endcase
    end

    // Relay drive register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            relayActive <= 1'b0;
        end else begin
            relayActive <= next_relay;
        end
    end

endmodule : ros_relay_select

/* ros_relay_select_properties.sv */
`timescale 1ns/1ps
// ----
// Port checker
// ----
module ros_relay_select_properties
    import ros_pkg::*;
(
    input wire logic                    clock,
    input wire logic                    reset_n,
    input wire ros_cfg_s                cfg,
    input wire logic                    cfgLoad,
    input wire ros_status_s             status,
    input wire ros_meas_s               meas,
    input wire logic signed [SPD_W-1:0] masterSpeed,
    input wire logic signed [SPD_W-1:0] minSpeed,
    input wire logic signed [SPD_W-1:0] maxSpeed,
    input wire logic                    relayActive,
    input wire logic signed [31:0]      ain1_result_display,
    input wire logic signed [SPD_W-1:0] followerSpeed,
    input wire logic                    followerMode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Same code loaded on two edges
    sequence s_fn(logic [3:0] c);
        (cfgLoad && cfg.relayFunction == c)[*2];
    endsequence
    // Threshold code, no band, settings steady
    sequence s_thr(logic [3:0] c);
        (cfgLoad && cfg.relayFunction == c && cfg.hysteresis == 16'sh0000 && $stable(cfg))[*3];
    endsequence
    AST_RUN: assert property (s_fn(4'h0) |=> relayActive == $past(status.motorEnabled))
        else $error("running code wrong");
    AST_OK: assert property (s_fn(4'h1) |=> relayActive == $past(status.powerOk && !status.fault))
        else $error("healthy code wrong");
    AST_SPD: assert property (s_fn(4'h2) |=> relayActive == $past(status.atSpeed))
        else $error("at speed code wrong");
    AST_TRIP: assert property (s_fn(4'h3) |=> relayActive == $past(status.fault))
        else $error("tripped code wrong");
    AST_RDY: assert property (s_fn(4'h9) |=> relayActive == $past(status.readyToRun && !status.fault))
        else $error("ready code wrong");
    AST_OVER: assert property (s_thr(4'h4) |=> relayActive == ($past(meas.speedPct, 2) >= $past(cfg.threshold, 2)))
        else $error("speed above wrong");
    AST_UNDER: assert property (s_thr(4'h7) |=> relayActive == ($past(meas.currentPct, 2) < $past(cfg.threshold, 2)))
        else $error("current below wrong");
    AST_FMODE: assert property ((cfgLoad && cfg.controlSource == SRC_FOLLOW)[*2] |=> followerMode)
        else $error("follower mode missing");
    AST_CLAMP: assert property (followerMode && $stable(minSpeed) && $stable(maxSpeed) |-> followerSpeed >= minSpeed && followerSpeed <= maxSpeed)
        else $error("follower speed off limits");
endmodule : ros_relay_select_properties

/* ros_relay_contacts.sv */
`timescale 1ns/1ps
// ----
// Relay contact pair outside the drive
// ----
module ros_relay_contacts (
    input  wire logic relayActive, // Coil drive
    output logic      contactsMade // Terminals joined
);
    // Contacts join while coil is energised
    assign contactsMade = relayActive;
endmodule : ros_relay_contacts

/* ros_relay_select_tb.sv */
`timescale 1ns/1ps
// ----
// Bench top
// ----
module ros_relay_select_tb import ros_pkg::*;;
    logic               clock = 1'b0;
    logic               reset_n = 1'b0;
    ros_cfg_s           cfg;
    logic               cfgLoad;
    ros_status_s        st;
    ros_meas_s          ms;
    logic signed [15:0] mstr, mn, mx, fSpd;
    logic               relayActive, fMode, made;
    logic signed [31:0] disp;
    int                 failures = 0;
    int                 n_tests = 0;
    int hv[7] = '{700, 550, 350, 550, 600, 650, 400}; // Hysteresis walk
    logic [6:0] he = 7'b1100011; // Expected, first at bit 6
    always #25 clock = ~clock; // 20 MHz
    ros_relay_select u_ros_relay_select (.clock(clock), .reset_n(reset_n), .cfg(cfg),
        .cfgLoad(cfgLoad), .status(st), .meas(ms), .masterSpeed(mstr), .minSpeed(mn),
        .maxSpeed(mx), .relayActive(relayActive), .ain1_result_display(disp),
        .followerSpeed(fSpd), .followerMode(fMode));
    ros_relay_contacts u_ros_relay_contacts (.relayActive(relayActive), .contactsMade(made));
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : step
    task cf(input logic [3:0] f, input logic signed [15:0] t, h, s, o, input logic [3:0] r);
        cfg = '{f, t, h, s, o, r};
    endtask : cf
    // Relay level from code, flags and level against 500
    function automatic logic expv(input int c, input ros_status_s s, input int v);
        case (c)
            0: return s.motorEnabled;
            1: return s.powerOk && !s.fault;
            2: return s.atSpeed;
            3: return s.fault;
            9: return s.readyToRun && !s.fault;
            6, 7: return v < 500;
            default: return v >= 500;
        endcase
    endfunction : expv
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        end_sim();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        int a[3] = '{600, 100, 600};
        int o[3] = '{100, 300, 100};
        int s[3] = '{2000, 1500, 30000};
        int r[3] = '{1000, -300, 10000};
        int m[3] = '{500, 100, 400};
        int k[3] = '{2000, 1000, 1500};
        int e[3] = '{800, 300, 600};
        logic signed [15:0] v;
        cf(1, THRESH_DEF, HYST_DEF, SCALE_DEF, OFFSET_DEF, 0);
        cfgLoad = 1'b0;
        st = 5'b01011;
        ms = '0;
        mstr = '0;
        mn = 16'sh012c;
        mx = 16'sh0320;
        repeat (6) @(negedge clock);
        chk(relayActive, 0);
        chk(fMode, 0);
        chk(disp, 0);
        reset_n = 1'b1;
        step(3);
        chk(relayActive, 1);
        cfg.relayFunction = 4'h3;
        step(3);
        chk(relayActive, 1);
        cfgLoad = 1'b1;
        for (int c = 0; c < 10; c++) for (int p = 0; p < 2; p++) begin
            v = p ? 16'sh0258 : 16'sh0190;
            cf(c, 500, 0, 1000, 0, 0);
            st = p ? 5'b10101 : 5'b01011;
            ms = '{v, v, v, v};
            step(4);
            chk({relayActive, made}, {2{expv(c, st, v)}});
        end
        cf(3, 500, 0, 1000, 0, 0);
        step(4);
        cf(12, 500, 0, 1000, 0, 0);
        step(4);
        // Code 12 loads as healthy; flags show a fault, so the relay drops
        chk(relayActive, 0);
        cf(4, 500, 100, 1000, 0, 0);
        for (int i = 0; i < 7; i++) begin
            ms = '{hv[i], 0, 0, 0};
            step(4);
            chk(relayActive, he[6-i]);
        end
        for (int i = 0; i < 3; i++) begin
            cf(1, 500, 0, s[i], o[i], 0);
            ms.ain1Pct = a[i];
            step(4);
            chk(disp, r[i]);
        end
        for (int i = 0; i < 3; i++) begin
            cf(1, 500, 0, k[i], 0, 9);
            mstr = m[i];
            step(4);
            chk({fMode, fSpd}, {1'b1, 16'(e[i])});
        end
        cf(1, 500, 0, 1000, 0, 0);
        step(4);
        chk({fMode, fSpd}, 17'h0);
        end_sim();
    end
endmodule : ros_relay_select_tb
bind ros_relay_select ros_relay_select_properties u_ros_relay_select_properties (
    .clock(clock), .reset_n(reset_n), .cfg(cfg), .cfgLoad(cfgLoad), .status(status),
    .meas(meas), .masterSpeed(masterSpeed), .minSpeed(minSpeed), .maxSpeed(maxSpeed),
    .relayActive(relayActive), .ain1_result_display(ain1_result_display),
    .followerSpeed(followerSpeed), .followerMode(followerMode));
